// ==== src/status_pkg.sv ====
// Shared constants and carrier types of the status reporting block.
package status_pkg;

  // ----------------------------------------------------------------
  // Status byte bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SB_RQS_MSS = 6;  // Requesting service or master summary.
  localparam int unsigned SB_ESB     = 5;  // Event summary.
  localparam int unsigned SB_MAV     = 4;  // Message available.
  localparam int unsigned SB_EAV     = 3;  // Error available.
  localparam int unsigned SB_ISB     = 2;  // Instrument summary.

  // ----------------------------------------------------------------
  // Event status bit positions and layout
  // ----------------------------------------------------------------
  localparam int unsigned EV_PON = 7;  // Power on.
  localparam int unsigned EV_CME = 5;  // Command error.
  localparam int unsigned EV_EXE = 4;  // Execution error.
  localparam int unsigned EV_DDE = 3;  // Device-dependent error.
  localparam int unsigned EV_QYE = 2;  // Query error.
  localparam int unsigned EV_OPC = 0;  // Operation complete.

  localparam logic [15:0] EV_IMPL_MASK  = 16'h00bd;  // Bits that can ever be 1.
  localparam logic [7:0]  SB_SUM_MASK   = 8'h3c;     // Summary bits 5 to 2.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_STB = 8'h00;
  localparam logic [7:0]  RST_SRE = 8'h00;
  localparam logic [15:0] RST_ESR = 16'h0000;
  localparam logic [15:0] RST_ESE = 16'h0000;

  // ----------------------------------------------------------------
  // Error queue sizing
  // ----------------------------------------------------------------
  localparam int unsigned ERRQ_KEEP  = 15;  // Ordinary entries kept.
  localparam int unsigned ERRQ_SLOTS = 16;  // Kept entries plus the overflow entry.
  localparam logic [4:0]  ERRQ_KEEP_C  = 5'h0f;
  localparam logic [4:0]  ERRQ_SLOTS_C = 5'h10;
  localparam logic [7:0]  ERR_EMPTY_CODE = 8'h00;  // Answer to a fetch from an empty queue.

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // One-cycle error and event pulses from the command engine.
  typedef struct packed {
    logic       cmd_err;   // Malformed or wrongly parameterised command.
    logic       exe_err;   // Command failed while executing.
    logic       dev_err;   // Device-specific command failed.
    logic       qry_err;   // Query error.
    logic [7:0] code;      // Error code queued with cmd, exe or dev errors.
  } err_evt_t;

  // Register writes and clearing messages from the command engine.
  typedef struct packed {
    logic       sre_wr;    // Write the service request enable mask.
    logic       ese_wr;    // Write the event enable mask.
    logic [15:0] wdata;    // Data for either write.
    logic       cls;       // Clear-status command.
    logic       rst;       // Reset command.
    logic       dcl;       // Device clear or selected device clear.
  } ctl_req_t;

endpackage

// ==== src/error_queue.sv ====
// Bounded error code queue with an overflow entry.
`timescale 1ns/1ps
module error_queue (
  input  wire logic       i_sys_clk,     // System clock.
  input  wire logic       i_nrst,        // Asynchronous reset, active low.
  input  wire logic       i_clear,       // Empty the queue.
  input  wire logic       i_push,        // Store one error code.
  input  wire logic [7:0] i_code,        // Code to store.
  input  wire logic [7:0] i_ovf_code,    // Code stored as the overflow entry.
  input  wire logic       i_pop,         // Fetch the oldest code.
  output logic [7:0]      o_code,        // Fetched code, registered.
  output logic            o_not_empty    // At least one entry waits.
);
  import status_pkg::*;

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [7:0] mem_q [ERRQ_SLOTS];  // Entry storage.
  logic [3:0] wr_ptr_q;            // Next slot to write.
  logic [3:0] rd_ptr_q;            // Oldest slot.
  logic [4:0] cnt_q;               // Entries held.
  logic [4:0] cnt_d;               // Next entry count.
  logic [7:0] code_q;              // Last fetched code.

  wire        pop_ok   = i_pop && (cnt_q != 5'h00);         // Fetch hits an entry.
  wire        room     = cnt_q < ERRQ_KEEP_C;               // Ordinary entry fits.
  wire        ovf_slot = cnt_q == ERRQ_KEEP_C;              // Only the overflow slot left.
  wire        push_ok  = i_push && (room || ovf_slot);      // Beyond that, discard.
  wire [7:0]  wr_code  = room ? i_code : i_ovf_code;        // Overflow entry replaces code.

  // The count moves up by an accepted push and down by an accepted pop.
  assign cnt_d = cnt_q + {4'h0, push_ok} - {4'h0, pop_ok};

  // Writes go only into the storage array; no reset needed on data.
  always_ff @(posedge i_sys_clk) begin
    if (push_ok) begin
      mem_q[wr_ptr_q] <= wr_code;
    end
  end

  // Pointers, count and the fetch answer.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      cnt_q    <= 5'h00;
      code_q   <= ERR_EMPTY_CODE;
    end else if (i_clear) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      cnt_q    <= 5'h00;
      code_q   <= ERR_EMPTY_CODE;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (i_pop) begin
        code_q <= pop_ok ? mem_q[rd_ptr_q] : ERR_EMPTY_CODE;
      end
      if (pop_ok) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      cnt_q <= cnt_d;
    end
  end

  assign o_code      = code_q;
  assign o_not_empty = cnt_q != 5'h00;

endmodule

// ==== src/status_reporting.sv ====
// Status byte, service request and event status logic of the remote interface.
`timescale 1ns/1ps
module status_reporting (
  input  wire logic                  i_sys_clk,        // System clock, 40 MHz.
  input  wire logic                  i_nrst,           // Asynchronous reset, active low.
  input  status_pkg::ctl_req_t       i_ctl,            // Writes and clearing messages.
  input  status_pkg::err_evt_t       i_err,            // Error event pulses.
  input  wire logic [7:0]            i_ovf_code,       // Overflow entry code.
  input  wire logic                  i_opc_cmd,        // Operation-complete command seen.
  input  wire logic                  i_ops_idle,       // All earlier commands finished.
  input  wire logic                  i_iface_ready,    // Interface can take a message.
  input  wire logic                  i_out_pending,    // Response data in output buffer.
  input  wire logic                  i_isb_connected,  // Instrument summary source present.
  input  wire logic                  i_isb,            // Instrument summary level.
  input  wire logic                  i_serial_mode,    // Remote link is the serial port.
  input  wire logic                  i_spoll,          // Serial poll performed.
  input  wire logic                  i_stb_rd,         // Status byte query.
  input  wire logic                  i_sre_rd,         // Request enable mask query.
  input  wire logic                  i_esr_rd,         // Event register query.
  input  wire logic                  i_ese_rd,         // Event enable mask query.
  input  wire logic                  i_fault_rd,       // Fetch one error code.
  output logic [7:0]                 o_poll_byte,      // Byte answered to a serial poll.
  output logic [15:0]                o_query_data,     // Answer to the last query.
  output logic [7:0]                 o_fault_code,     // Answer to the last error fetch.
  output logic                       o_srq_o,          // Request line level when driven.
  output logic                       o_srq_oe,         // Request line driven low.
  output logic                       o_send_req_str    // Send the serial request string.
);
  import status_pkg::*;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  logic [7:0]  request_enable_mask_q;   // Service request enable mask.
  logic [15:0] event_status_reg_q;      // Latched event bits.
  logic [15:0] event_status_reg_d;      // Next event bits.
  logic [15:0] event_enable_mask_q;     // Event enable mask.
  logic        requesting_service_q;    // Requesting service bit.
  logic        requesting_service_d;    // Next requesting service bit.
  logic [7:0]  summary_prev_q;          // Summary bits one cycle ago.
  logic        pon_pending_q;           // Power cycle not yet recorded.
  logic        opc_armed_q;             // Waiting to flag operation complete.
  logic [7:0]  poll_byte_q;             // Registered poll answer.
  logic [15:0] query_q;                 // Registered query answer.
  logic        send_str_q;              // Registered string send pulse.

  // ----------------------------------------------------------------
  // Summary decode
  // ----------------------------------------------------------------
  logic        error_available_bit;      // Error queue not empty.
  logic        event_summary_bit;        // Any enabled event bit set.
  logic        instrument_summary_bit;   // Gated instrument summary.
  logic        message_available_bit;    // Output data waiting.
  logic        master_summary_bit;       // Any enabled summary bit set.
  logic [7:0]  summary_bits;             // Summary bits in byte position.
  logic [7:0]  poll_status_byte;         // Byte with requesting-service in bit 6.
  logic [7:0]  query_status_byte;        // Byte with master summary in bit 6.
  logic        rqs_set;                  // Enabled summary bit rose.
  logic        rqs_clr;                  // Clearing cause for requesting service.
  logic        esr_clr;                  // Clearing cause for the event register.
  logic        opc_fire;                 // Operation complete now.
  logic [15:0] ev_set;                   // Event bits set this cycle.

  // Puts one summary flag on its byte position, others zero.
  function automatic logic [7:0] place_bit(input logic b, input int unsigned pos);
    logic [7:0] v;
    v = 8'h00;
    v[pos[2:0]] = b;
    return v;
  endfunction

  // Asks whether any bit of a field is set under its enable mask.
  function automatic logic any_enabled(input logic [15:0] bits, input logic [15:0] mask);
    return |(bits & mask);
  endfunction

  assign event_summary_bit      = any_enabled(event_status_reg_q, event_enable_mask_q);
  assign message_available_bit  = i_out_pending;
  assign instrument_summary_bit = i_isb_connected & i_isb;

  // Summary bits 5..2; bits 7, 1 and 0 never carry anything.
  assign summary_bits = place_bit(event_summary_bit, SB_ESB)
                      | place_bit(message_available_bit, SB_MAV)
                      | place_bit(error_available_bit, SB_EAV)
                      | place_bit(instrument_summary_bit, SB_ISB);

  assign master_summary_bit = any_enabled({8'h00, summary_bits},
                                          {8'h00, request_enable_mask_q & SB_SUM_MASK});

  assign poll_status_byte  = summary_bits | place_bit(requesting_service_q, SB_RQS_MSS);
  assign query_status_byte = summary_bits | place_bit(master_summary_bit, SB_RQS_MSS);

  // ----------------------------------------------------------------
  // Requesting service control
  // ----------------------------------------------------------------
  // A set needs a 0-to-1 step of an enabled summary bit; it wins over a poll clear.
  assign rqs_set = |(summary_bits & ~summary_prev_q & request_enable_mask_q & SB_SUM_MASK);
  assign rqs_clr = i_spoll | i_ctl.cls | ~master_summary_bit;
  assign requesting_service_d = rqs_set ? 1'b1 :
                                rqs_clr ? 1'b0 : requesting_service_q;

  // ----------------------------------------------------------------
  // Event register next value
  // ----------------------------------------------------------------
  // The engine must see the pending work done and the interface free.
  assign opc_fire = opc_armed_q & i_ops_idle & i_iface_ready;

  assign ev_set = ({8'h00, place_bit(pon_pending_q, EV_PON)}
                 | {8'h00, place_bit(i_err.cmd_err, EV_CME)}
                 | {8'h00, place_bit(i_err.exe_err, EV_EXE)}
                 | {8'h00, place_bit(i_err.dev_err, EV_DDE)}
                 | {8'h00, place_bit(i_err.qry_err, EV_QYE)}
                 | {8'h00, place_bit(opc_fire, EV_OPC)}) & EV_IMPL_MASK;

  // Latched bits drop only on a read or a clearing message.
  assign esr_clr = i_esr_rd | i_ctl.dcl | i_ctl.rst | i_ctl.cls;

  // New events are ORed after the clear so that none is lost.
  assign event_status_reg_d = ((esr_clr ? RST_ESR : event_status_reg_q) | ev_set)
                            & EV_IMPL_MASK;

  // ----------------------------------------------------------------
  // Error queue
  // ----------------------------------------------------------------
  // Codes from command, execution and device errors; clear-status empties it.
  error_queue u_error_queue (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_clear     (i_ctl.cls),
    .i_push      (i_err.cmd_err | i_err.exe_err | i_err.dev_err),
    .i_code      (i_err.code),
    .i_ovf_code  (i_ovf_code),
    .i_pop       (i_fault_rd),
    .o_code      (o_fault_code),
    .o_not_empty (error_available_bit)
  );

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  // Masks clear at reset only; reads leave them untouched.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      request_enable_mask_q <= RST_SRE;
      event_enable_mask_q   <= RST_ESE;
    end else begin
      if (i_ctl.sre_wr) begin
        request_enable_mask_q <= i_ctl.wdata[7:0];
      end
      if (i_ctl.ese_wr) begin
        event_enable_mask_q <= i_ctl.wdata & EV_IMPL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event register, power-on marker and operation-complete arming
  // ----------------------------------------------------------------
  // The power-on marker is a constant at reset and lands on the first edge after.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      event_status_reg_q <= RST_ESR;
      pon_pending_q      <= 1'b1;
      opc_armed_q        <= 1'b0;
    end else begin
      event_status_reg_q <= event_status_reg_d;
      pon_pending_q      <= 1'b0;
      if (i_ctl.cls | i_ctl.rst) begin
        opc_armed_q <= 1'b0;  // Clear-status cancels pending completion.
      end else if (i_opc_cmd) begin
        opc_armed_q <= 1'b1;
      end else if (opc_fire) begin
        opc_armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Requesting service, edge history and string pulse
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      requesting_service_q <= 1'b0;
      summary_prev_q       <= 8'h00;
      send_str_q           <= 1'b0;
    end else begin
      requesting_service_q <= requesting_service_d;
      summary_prev_q       <= summary_bits;
      // One pulse per rise of the request condition on the serial link.
      send_str_q <= i_serial_mode & requesting_service_d & ~requesting_service_q;
    end
  end

  // ----------------------------------------------------------------
  // Answers
  // ----------------------------------------------------------------
  // The poll byte tracks the live value; queries capture on their strobe.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      poll_byte_q <= RST_STB;
      query_q     <= 16'h0000;
    end else begin
      poll_byte_q <= poll_status_byte;
      if (i_stb_rd) begin
        query_q <= {8'h00, query_status_byte};
      end else if (i_sre_rd) begin
        query_q <= {8'h00, request_enable_mask_q};
      end else if (i_esr_rd) begin
        query_q <= event_status_reg_q;
      end else if (i_ese_rd) begin
        query_q <= event_enable_mask_q;
      end
    end
  end

  // Open-drain request line: pulled low while requesting on the bus link.
  assign o_srq_o        = 1'b0;
  assign o_srq_oe       = requesting_service_q & ~i_serial_mode;
  assign o_poll_byte    = poll_byte_q;
  assign o_query_data   = query_q;
  assign o_send_req_str = send_str_q;

endmodule

// ==== verification/status_reporting_sva.sv ====
// Concurrent checks on the ports of the status reporting block.
`timescale 1ns/1ps
module status_reporting_sva (
  input wire logic            i_sys_clk,       // System clock.
  input wire logic            i_nrst,          // Reset, active low.
  input status_pkg::ctl_req_t i_ctl,           // Writes and clearing messages.
  input status_pkg::err_evt_t i_err,           // Error pulses.
  input wire logic            i_serial_mode,   // Serial link selected.
  input wire logic            i_spoll,         // Serial poll done.
  input wire logic            i_stb_rd,        // Status byte query.
  input wire logic            i_sre_rd,        // Request mask query.
  input wire logic            i_esr_rd,        // Event register query.
  input wire logic            i_ese_rd,        // Event mask query.
  input wire logic            i_fault_rd,      // Error fetch.
  input wire logic [7:0]      o_poll_byte,     // Poll byte.
  input wire logic [15:0]     o_query_data,    // Query answer.
  input wire logic            o_srq_o,         // Request line level.
  input wire logic            o_srq_oe,        // Request line enable.
  input wire logic            o_send_req_str   // Request string pulse.
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // A mask write, one quiet cycle, then a lone read of that mask.
  sequence ese_then_read;
    i_ctl.ese_wr ##1 !i_ctl.ese_wr
      ##1 (i_ese_rd && !i_stb_rd && !i_sre_rd && !i_esr_rd && !i_ctl.ese_wr && !i_ctl.rst);
  endsequence
  sequence sre_then_read;
    i_ctl.sre_wr ##1 !i_ctl.sre_wr ##1 (i_sre_rd && !i_stb_rd && !i_ctl.sre_wr && !i_ctl.rst);
  endsequence
  // A command error that no clear or fetch can remove for two cycles.
  sequence err_kept;
    (i_err.cmd_err && !i_ctl.cls && !i_fault_rd) ##1 (!i_ctl.cls && !i_fault_rd);
  endsequence
  poll_zero_a: assert property (o_poll_byte[7] == 1'b0 && o_poll_byte[1:0] == 2'b00)
    else $error("poll byte reserved bits set");
  srq_drive_a: assert property (o_srq_o == 1'b0 && !(o_srq_oe && i_serial_mode))
    else $error("request line driven wrongly");
  srq_rqs_a: assert property ($rose(o_srq_oe) |=> o_poll_byte[6])
    else $error("request line without service bit in poll byte");
  poll_clear_a: assert property (i_spoll && o_srq_oe |=> !o_srq_oe)
    else $error("poll left request standing");
  cls_clear_a: assert property (i_ctl.cls |=> !o_srq_oe)
    else $error("clear status left request standing");
  str_pulse_a: assert property (o_send_req_str |-> i_serial_mode ##1 !o_send_req_str)
    else $error("request string pulse malformed");
  ese_keep_a: assert property (ese_then_read |=> o_query_data == ($past(i_ctl.wdata, 3) & 16'h00bd))
    else $error("event mask read differs from write");
  sre_keep_a: assert property (sre_then_read |=> o_query_data == ($past(i_ctl.wdata, 3) & 16'h00ff))
    else $error("request mask read differs from write");
  eav_set_a: assert property (err_kept |=> o_poll_byte[3])
    else $error("error available bit missing after error");
endmodule
bind status_reporting status_reporting_sva chk (.*);

// ==== verification/host_poll_model.sv ====
// Host controller model that answers a service request with a serial poll.
`timescale 1ns/1ps
module host_poll_model (
  input  wire logic       i_sys_clk,    // System clock.
  input  wire logic       i_nrst,       // Reset, active low.
  input  wire logic       i_enable,     // Poll when a request is seen.
  input  wire logic [7:0] i_wait,       // Cycles of hesitation before a poll.
  input  wire logic       i_srq_oe,     // Request line pulled low.
  input  wire logic [7:0] i_poll_byte,  // Byte the device answers.
  output logic            o_spoll,      // Serial poll done.
  output logic [7:0]      o_byte,       // Byte read by the last poll.
  output logic [7:0]      o_polls       // Number of polls made.
);
  logic [7:0] wait_q;  // Cycles waited on the current request.
  // A poll lasts one cycle and reads the byte at its end.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q <= 8'h00;
      o_spoll <= 1'b0;
      o_byte <= 8'h00;
      o_polls <= 8'h00;
    end else begin
      o_spoll <= 1'b0;
      if (o_spoll) begin
        o_byte <= i_poll_byte;
        o_polls <= o_polls + 8'h01;
      end
      if (!i_enable || !i_srq_oe || o_spoll) begin
        wait_q <= 8'h00;
      end else if (wait_q < i_wait) begin
        wait_q <= wait_q + 8'h01;
      end else begin
        o_spoll <= 1'b1;
      end
    end
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench of the status reporting block.
`timescale 1ns/1ps
module testbench;
  import status_pkg::*;
  logic i_sys_clk, i_nrst, i_opc_cmd, i_ops_idle, i_iface_ready, i_out_pending, i_isb;
  logic i_isb_connected, i_serial_mode, i_spoll, i_stb_rd, i_sre_rd, i_esr_rd, i_ese_rd;
  logic i_fault_rd, o_srq_o, o_srq_oe, o_send_req_str, host_en;
  ctl_req_t i_ctl;
  err_evt_t i_err;
  logic [7:0] i_ovf_code, o_poll_byte, o_fault_code, host_byte, host_polls, host_wait;
  logic [15:0] o_query_data;
  int n_fail = 0, num_checks = 0, n_str = 0;
  status_reporting uut (.*);
  host_poll_model host (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_enable(host_en),
    .i_wait(host_wait), .i_srq_oe(o_srq_oe), .i_poll_byte(o_poll_byte), .o_spoll(i_spoll),
    .o_byte(host_byte), .o_polls(host_polls));
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // Request string pulses are counted for the serial link case.
  always @(posedge i_sys_clk) if (o_send_req_str === 1'b1) n_str++;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Queries: 0 status byte, 1 request mask, 2 event register, 3 event mask.
  task automatic query(input int sel, input logic [15:0] exp);
    @(posedge i_sys_clk);
    {i_stb_rd, i_sre_rd, i_esr_rd, i_ese_rd} <= 4'(4'h8 >> sel);
    @(posedge i_sys_clk);
    {i_stb_rd, i_sre_rd, i_esr_rd, i_ese_rd} <= 4'h0;
    tick(1);
    check(o_query_data, exp);
  endtask
  task automatic write(input bit event_status_enable, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_ctl.sre_wr <= !event_status_enable;
    i_ctl.ese_wr <= event_status_enable;
    i_ctl.wdata <= d;
    @(posedge i_sys_clk);
    i_ctl.sre_wr <= 1'b0;
    i_ctl.ese_wr <= 1'b0;
  endtask
  // Error kinds in order command, execution, device, query.
  task automatic fire(input logic [3:0] kind, input logic [7:0] code);
    @(posedge i_sys_clk);
    {i_err.cmd_err, i_err.exe_err, i_err.dev_err, i_err.qry_err} <= kind;
    i_err.code <= code;
    @(posedge i_sys_clk);
    {i_err.cmd_err, i_err.exe_err, i_err.dev_err, i_err.qry_err} <= 4'h0;
  endtask
  task automatic clr(input logic [2:0] k);
    @(posedge i_sys_clk);
    {i_ctl.cls, i_ctl.rst, i_ctl.dcl} <= k;
    @(posedge i_sys_clk);
    {i_ctl.cls, i_ctl.rst, i_ctl.dcl} <= 3'h0;
  endtask
  task automatic fetch(input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_fault_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_fault_rd <= 1'b0;
    tick(1);
    check(o_fault_code, exp);
  endtask
  task automatic await_poll(input logic [7:0] n);
    for (int k = 0; k < 50 && host_polls !== n; k++) tick(1);
    if (host_polls !== n) begin
      n_fail++;
      wrap_up();
    end
  endtask
  initial begin
    tick(20000);
    n_fail++;
    wrap_up();
  end
  initial begin
    {i_nrst, i_opc_cmd, i_ops_idle, i_out_pending, i_isb_connected, i_serial_mode} = 6'h0;
    {i_stb_rd, i_sre_rd, i_esr_rd, i_ese_rd, i_fault_rd, host_en} = 6'h01;
    {i_iface_ready, i_isb} = 2'h3;
    i_ctl = '0;
    i_err = '0;
    i_ovf_code = 8'hee;
    host_wait = 8'h05;
    repeat (12) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    tick(1);
    check(o_poll_byte, 8'h00);
    query(1, 16'h0000);
    query(3, 16'h0000);
    query(2, 16'h0080);
    query(2, 16'h0000);
    write(1, 16'hffff);
    query(3, 16'h00bd);
    query(3, 16'h00bd);
    for (int j = 0; j < 4; j++) begin
      fire(4'(4'h8 >> j), 8'(8'h10 + j));
      query(2, 16'(16'h0020 >> j));
    end
    check(o_poll_byte, 8'h08);
    for (int j = 0; j < 3; j++) fetch(8'(8'h10 + j));
    fetch(8'h00);
    check(o_poll_byte, 8'h00);
    // A slow host polls after an enabled command error.
    write(0, 16'h0020);
    query(1, 16'h0020);
    fire(4'h8, 8'h21);
    await_poll(8'h01);
    check(host_byte, 8'h68);
    tick(2);
    check(o_srq_oe, 1'b0);
    query(0, 16'h0068);
    check(o_poll_byte, 8'h28);
    query(2, 16'h0020);
    // An error in the cycle of a read survives the read.
    host_en = 1'b0;
    @(posedge i_sys_clk);
    i_esr_rd <= 1'b1;
    i_err.cmd_err <= 1'b1;
    @(posedge i_sys_clk);
    i_esr_rd <= 1'b0;
    i_err.cmd_err <= 1'b0;
    tick(1);
    check(o_query_data, 16'h0000);
    query(2, 16'h0020);
    tick(3);
    check(o_srq_oe, 1'b0);
    // Clear status, device clear and reset each empty the event register.
    for (int j = 0; j < 3; j++) begin
      fire(4'h8, 8'h22);
      clr(j == 0 ? 3'h4 : (j == 1 ? 3'h1 : 3'h2));
      query(2, 16'h0000);
    end
    write(1, 16'h00bd);
    write(0, 16'h0020);
    clr(3'h4);
    for (int j = 1; j <= 17; j++) fire(4'h4, 8'(j));
    for (int j = 1; j <= 15; j++) fetch(8'(j));
    fetch(8'hee);
    fetch(8'h00);
    clr(3'h4);
    @(posedge i_sys_clk);
    i_serial_mode <= 1'b1;
    fire(4'h8, 8'h30);
    tick(4);
    check(16'(n_str), 16'h0001);
    check(o_srq_oe, 1'b0);
    clr(3'h4);
    i_serial_mode <= 1'b0;
    // A prompt host polls when a message becomes available.
    {host_en, host_wait} = 9'h100;
    write(0, 16'h0010);
    i_out_pending <= 1'b1;
    await_poll(8'h02);
    check(host_byte, 8'h50);
    host_en = 1'b0;
    @(posedge i_sys_clk);
    i_out_pending <= 1'b0;
    tick(3);
    check(o_poll_byte, 8'h00);
    @(posedge i_sys_clk);
    i_opc_cmd <= 1'b1;
    @(posedge i_sys_clk);
    i_opc_cmd <= 1'b0;
    tick(4);
    query(2, 16'h0000);
    i_ops_idle <= 1'b1;
    tick(3);
    query(2, 16'h0001);
    query(0, 16'h0000);
    i_isb_connected <= 1'b1;
    query(0, 16'h0004);
    wrap_up();
  end
endmodule
